// File: core/ufc_pkg.sv
// Package for the UART FIFO control block: offsets, levels, field layouts
package ufc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and responses
  // ----------------------------------------------------------------
  localparam int UFC_ADDR_W = 8;                 // Byte address width of the register window
  localparam logic [1:0] UFC_RESP_OKAY = 2'h0;   // Normal completion
  localparam logic [1:0] UFC_RESP_SLVERR = 2'h2; // Unmapped offset

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_FIFO_CONTROL = 8'h00;    // Write only
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_ENHANCED = 8'h04;        // Enhanced function enable
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_HOLDING = 8'h08;         // Write pushes tx, read pops rx
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_STATUS = 8'h0C;          // Live state, read only
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_IRQ_STATUS = 8'h10;      // Sticky events, write one clears
  localparam logic [UFC_ADDR_W-1:0] UFC_OFS_IRQ_MASK = 8'h14;        // One enables an event

  // ----------------------------------------------------------------
  // FIFO geometry and trigger levels
  // ----------------------------------------------------------------
  localparam int UFC_DEPTH = 64;       // Entries per holding store
  localparam int UFC_CHAR_W = 8;       // Character width
  localparam int UFC_ERR_W = 3;        // Break, framing, parity per character
  localparam int UFC_CNT_W = 7;        // Fill count, 0..64
  localparam int UFC_EFR_ENH_BIT = 4;  // Enhanced function enable position
  localparam logic [UFC_CNT_W-1:0] UFC_RX_LVL0 = 7'h08;  // 8 characters
  localparam logic [UFC_CNT_W-1:0] UFC_RX_LVL1 = 7'h10;  // 16 characters
  localparam logic [UFC_CNT_W-1:0] UFC_RX_LVL2 = 7'h38;  // 56 characters
  localparam logic [UFC_CNT_W-1:0] UFC_RX_LVL3 = 7'h3C;  // 60 characters
  localparam logic [UFC_CNT_W-1:0] UFC_TX_LVL0 = 7'h08;  // 8 spaces
  localparam logic [UFC_CNT_W-1:0] UFC_TX_LVL1 = 7'h10;  // 16 spaces
  localparam logic [UFC_CNT_W-1:0] UFC_TX_LVL2 = 7'h20;  // 32 spaces
  localparam logic [UFC_CNT_W-1:0] UFC_TX_LVL3 = 7'h38;  // 56 spaces

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  // FIFO control byte, bit 7 first
  typedef struct packed {
    logic [1:0] rx_trig;   // Receive threshold code
    logic [1:0] tx_trig;   // Transmit threshold code
    logic dma_mode;        // DMA signalling mode
    logic tx_reset;        // Transmit FIFO flush request
    logic rx_reset;        // Receive FIFO flush request
    logic fifo_en;         // Receive FIFO enabled
  } ufc_fcr_t;

  // Interrupt event bits, shared by status and mask
  typedef struct packed {
    logic tx_overflow;     // Write to a full transmit FIFO
    logic rx_overflow;     // Character lost on receive
    logic tx_hit;          // Transmit threshold reached
    logic rx_hit;          // Receive threshold reached
  } ufc_irq_t;

  // Status word as read by software
  typedef struct packed {
    logic [4:0] zero;              // Reads as zero
    logic efr_enh;                 // Enhanced function enable
    logic tx_hit;                  // Transmit threshold level
    logic rx_hit;                  // Receive threshold level
    logic [7:0] fifo_control;               // Live FIFO control bits
    logic [UFC_CNT_W:0] tx_count;  // Transmit fill, zero padded
    logic [UFC_CNT_W:0] rx_count;  // Receive fill, zero padded
  } ufc_status_t;

  // Receive entry: error status beside the character
  typedef struct packed {
    logic [UFC_ERR_W-1:0] err;
    logic [UFC_CHAR_W-1:0] data;
  } ufc_rx_entry_t;

endpackage : ufc_pkg

// File: core/ufc_fifo.sv
// Flip-flop FIFO with flush, used for both holding stores
`timescale 1ns/1ps
`default_nettype none

module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int CW = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  // Fill state
  output logic full,
  output logic empty,
  output logic [CW-1:0] count
);

  localparam int AW = $clog2(DEPTH);  // Pointer width; DEPTH must be a power of two

  // All state of the FIFO
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage, one flop word per entry
    logic [AW-1:0] wr_ptr;             // Next write slot
    logic [AW-1:0] rd_ptr;             // Oldest entry
    logic [CW-1:0] cnt;                // Entries held
  } ufc_fifo_st_t;

  ufc_fifo_st_t s_r;
  ufc_fifo_st_t s_nxt;
  logic push_ok;
  logic pop_ok;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Flush wins; a push in the flush cycle lands in slot zero
  always_comb
  begin
    s_nxt = s_r;
    push_ok = 1'b0;
    pop_ok = 1'b0;
    if (flush)
    begin
      s_nxt.wr_ptr = '0;
      s_nxt.rd_ptr = '0;
      s_nxt.cnt = '0;
      if (push)
      begin
        s_nxt.mem[0] = push_data;
        s_nxt.wr_ptr = AW'(1);
        s_nxt.cnt = CW'(1);
      end
    end
    else
    begin
      // A pop frees room for a push in the same cycle
      pop_ok = pop && !empty;
      push_ok = push && (!full || pop_ok);
      if (push_ok)
      begin
        s_nxt.mem[s_r.wr_ptr] = push_data;
        s_nxt.wr_ptr = AW'(s_r.wr_ptr + AW'(1));
      end
      if (pop_ok)
        s_nxt.rd_ptr = AW'(s_r.rd_ptr + AW'(1));
      s_nxt.cnt = CW'(s_r.cnt + CW'(push_ok) - CW'(pop_ok));
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the flops
  assign pop_data = s_r.mem[s_r.rd_ptr];
  assign count = s_r.cnt;
  assign empty = (s_r.cnt == '0);
  assign full = (s_r.cnt == CW'(DEPTH));

endmodule : ufc_fifo

`default_nettype wire

// File: core/ufc_level.sv
// Threshold decode and compare for one trigger field
`timescale 1ns/1ps
`default_nettype none

module ufc_level #(
  parameter bit IS_RX = 1'b1
) (
  // Threshold code and the fill to compare
  input wire logic [1:0] sel,
  input wire logic [ufc_pkg::UFC_CNT_W-1:0] fill,
  // Reached
  output logic hit
);

  logic [ufc_pkg::UFC_CNT_W-1:0] level;  // Decoded threshold

  // Receive counts characters, transmit counts free spaces
  always_comb
  begin
    unique case (sel)
      2'h0: level = IS_RX ? ufc_pkg::UFC_RX_LVL0 : ufc_pkg::UFC_TX_LVL0;
      2'h1: level = IS_RX ? ufc_pkg::UFC_RX_LVL1 : ufc_pkg::UFC_TX_LVL1;
      2'h2: level = IS_RX ? ufc_pkg::UFC_RX_LVL2 : ufc_pkg::UFC_TX_LVL2;
      2'h3: level = IS_RX ? ufc_pkg::UFC_RX_LVL3 : ufc_pkg::UFC_TX_LVL3;
    endcase
    hit = (fill >= level);
  end

endmodule : ufc_level

`default_nettype wire

// File: core/ufc_top.sv
// UART FIFO control: AXI4-Lite slave, control byte, holding FIFOs, interrupt
//
// Overview of operation
// - Control register is write only, reads zero
// - Bits 7:6 pick receive threshold 8/16/56/60
// - Bits 5:4 pick transmit free-space threshold
// - Transmit threshold writable only with enhanced enable
// - Bit 3 selects DMA signalling mode
// - Bit 2 flushes transmit FIFO, zero ignored
// - Transmit flush leaves shift register alone
// - Bit 1 flushes receive FIFO, zero ignored
// - Receive flush leaves shift register alone
// - Flush bits clear themselves after flushing
// - Bit 0 enables or disables the receive FIFO; the transmit FIFO is always on
// - Enable and flush bits reset to zero
// - Two 64-entry byte FIFOs, receive keeps errors
// - Disabled receive uses slot zero, overwrites
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ufc_top #(
  parameter int DEPTH = ufc_pkg::UFC_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [ufc_pkg::UFC_ADDR_W-1:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  // AXI4-Lite write data
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  // AXI4-Lite write response
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  output logic [1:0] s_axil_bresp,
  // AXI4-Lite read address
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  input wire logic [ufc_pkg::UFC_ADDR_W-1:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  // AXI4-Lite read data
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  // Transmit shift register side
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [ufc_pkg::UFC_CHAR_W-1:0] tx_data,
  // Receive shift register side
  input wire logic rx_valid,
  input wire ufc_pkg::ufc_rx_entry_t rx_entry,
  // Mode and threshold indications
  output logic fifo_enable,
  output logic dma_mode,
  output logic rx_trigger,
  output logic tx_trigger,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int ENTRY_W = ufc_pkg::UFC_CHAR_W + ufc_pkg::UFC_ERR_W;  // Receive entry width

  // All state of the block
  typedef struct packed {
    logic aw_held;                               // Write address captured
    logic [ufc_pkg::UFC_ADDR_W-1:0] aw_addr;     // Captured write address
    logic w_held;                                // Write data captured
    logic [31:0] wdata;                          // Captured write data
    logic [3:0] wstrb;                           // Captured byte strobes
    logic bvalid;                                // Write response pending
    logic [1:0] bresp;                           // Write response code
    logic rvalid;                                // Read data pending
    logic [1:0] rresp;                           // Read response code
    logic [31:0] rdata;                          // Read data
    ufc_pkg::ufc_fcr_t fifo_control;                      // Live FIFO control bits
    logic efr_enh;                               // Enhanced function enable
    ufc_pkg::ufc_irq_t irq_status;               // Sticky events
    ufc_pkg::ufc_irq_t irq_mask;                 // Event enables
    logic rx_hit;                                // Registered receive threshold
    logic tx_hit;                                // Registered transmit threshold
  } ufc_top_st_t;

  ufc_top_st_t s_r;
  ufc_top_st_t s_nxt;

  // FIFO hookup
  logic tx_push;                                 // Holding write from software
  logic tx_full;
  logic tx_empty;
  logic [ufc_pkg::UFC_CNT_W-1:0] tx_count;
  logic [ufc_pkg::UFC_CNT_W-1:0] tx_free;        // Free spaces for the threshold
  logic rx_push;                                 // Character into receive store
  logic rx_flush;                                // Flush or overwrite in slot zero
  logic rx_pop;                                  // Holding read from software
  logic rx_full;
  logic rx_empty;
  logic [ufc_pkg::UFC_CNT_W-1:0] rx_count;
  logic [ENTRY_W-1:0] rx_head;                   // Oldest receive entry
  logic rx_hit_now;                              // Live receive threshold compare
  logic tx_hit_now;                              // Live transmit threshold compare

  // Bus decode
  logic wr_fire;                                 // Both halves of a write held
  logic rd_fire;                                 // Read address taken
  logic [ufc_pkg::UFC_ADDR_W-1:0] wr_ofs;        // Word aligned write offset
  logic [ufc_pkg::UFC_ADDR_W-1:0] rd_ofs;        // Word aligned read offset
  ufc_pkg::ufc_fcr_t wr_fcr;                     // Write data seen as control byte
  ufc_pkg::ufc_irq_t wr_irq;                     // Write data seen as event bits
  ufc_pkg::ufc_irq_t events;                     // Events raised this cycle
  ufc_pkg::ufc_status_t status;                  // Status word
  ufc_pkg::ufc_rx_entry_t rx_word;               // Receive head, split

  // ----------------------------------------------------------------
  // Holding stores
  // ----------------------------------------------------------------
  // transmit 64-entry store
  ufc_fifo #(
    .WIDTH(ufc_pkg::UFC_CHAR_W),
    .DEPTH(DEPTH),
    .CW(ufc_pkg::UFC_CNT_W)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(s_r.fifo_control.tx_reset),
    .push(tx_push),
    .push_data(s_r.wdata[ufc_pkg::UFC_CHAR_W-1:0]),
    .pop(tx_valid && tx_ready),
    .pop_data(tx_data),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );

  // input side is only a strobe, shift register unaffected
  ufc_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH),
    .CW(ufc_pkg::UFC_CNT_W)
  ) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(rx_flush),
    .push(rx_push),
    .push_data(rx_entry),
    .pop(rx_pop),
    .pop_data(rx_head),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );

  ufc_level #(
    .IS_RX(1'b1)
  ) u_rx_level (
    .sel(s_r.fifo_control.rx_trig),
    .fill(rx_count),
    .hit(rx_hit_now)
  );

  ufc_level #(
    .IS_RX(1'b0)
  ) u_tx_level (
    .sel(s_r.fifo_control.tx_trig),
    .fill(tx_free),
    .hit(tx_hit_now)
  );

  // ----------------------------------------------------------------
  // Datapath glue
  // ----------------------------------------------------------------
  // Decode helpers and FIFO strobes
  always_comb
  begin
    tx_free = ufc_pkg::UFC_CNT_W'(DEPTH) - tx_count;
    wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    rd_fire = s_axil_arvalid && !s_r.rvalid;
    wr_ofs = {s_r.aw_addr[ufc_pkg::UFC_ADDR_W-1:2], 2'h0};
    rd_ofs = {s_axil_araddr[ufc_pkg::UFC_ADDR_W-1:2], 2'h0};
    wr_fcr = s_r.wdata[7:0];
    wr_irq = s_r.wdata[3:0];
    rx_word = rx_head;
    // Holding write needs the low byte lane
    tx_push = wr_fire && (wr_ofs == ufc_pkg::UFC_OFS_HOLDING) && s_r.wstrb[0];
    // Popping an empty store is harmless, the FIFO ignores it
    rx_pop = rd_fire && (rd_ofs == ufc_pkg::UFC_OFS_HOLDING);
    rx_push = rx_valid;
    // flush while the pending bit stands
    rx_flush = s_r.fifo_control.rx_reset || (!s_r.fifo_control.fifo_en && rx_valid);
    // Events of this cycle
    events.rx_hit = rx_hit_now && !s_r.rx_hit;
    events.tx_hit = tx_hit_now && !s_r.tx_hit;
    events.rx_overflow = rx_valid && (s_r.fifo_control.fifo_en ? (rx_full && !rx_pop) : !rx_empty);
    events.tx_overflow = tx_push && tx_full && !(tx_valid && tx_ready);
    // Status word
    status.zero = '0;
    status.efr_enh = s_r.efr_enh;
    status.tx_hit = s_r.tx_hit;
    status.rx_hit = s_r.rx_hit;
    status.fifo_control = s_r.fifo_control;
    status.tx_count = {1'h0, tx_count};
    status.rx_count = {1'h0, rx_count};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus channels, register writes, self clearing flushes, events
  always_comb
  begin
    s_nxt = s_r;
    // Thresholds are registered so the outputs come from flops
    s_nxt.rx_hit = rx_hit_now;
    s_nxt.tx_hit = tx_hit_now;
    // flush bits drop once the flush cycle is done
    s_nxt.fifo_control.tx_reset = 1'b0;
    s_nxt.fifo_control.rx_reset = 1'b0;

    // Capture address and data in either order
    if (s_axil_awvalid && s_axil_awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axil_wdata;
      s_nxt.wstrb = s_axil_wstrb;
    end

    // Execute a write once both halves are in
    if (wr_fire)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = ufc_pkg::UFC_RESP_OKAY;
      unique case (wr_ofs)
        ufc_pkg::UFC_OFS_FIFO_CONTROL:
        begin
          if (s_r.wstrb[0])
          begin
            s_nxt.fifo_control.rx_trig = wr_fcr.rx_trig;
            if (s_r.efr_enh)
              s_nxt.fifo_control.tx_trig = wr_fcr.tx_trig;
            s_nxt.fifo_control.dma_mode = wr_fcr.dma_mode;
            // a zero leaves the flush bits alone
            s_nxt.fifo_control.tx_reset = wr_fcr.tx_reset;
            s_nxt.fifo_control.rx_reset = wr_fcr.rx_reset;
            s_nxt.fifo_control.fifo_en = wr_fcr.fifo_en;
          end
        end
        ufc_pkg::UFC_OFS_ENHANCED:
        begin
          if (s_r.wstrb[0])
            s_nxt.efr_enh = s_r.wdata[ufc_pkg::UFC_EFR_ENH_BIT];
        end
        ufc_pkg::UFC_OFS_HOLDING:
        begin
          // Push handled by the FIFO strobe
        end
        ufc_pkg::UFC_OFS_STATUS:
        begin
          // Read only, write dropped
        end
        ufc_pkg::UFC_OFS_IRQ_STATUS:
        begin
          // Write one clears, applied before new events
          if (s_r.wstrb[0])
            s_nxt.irq_status = s_r.irq_status & ~wr_irq;
        end
        ufc_pkg::UFC_OFS_IRQ_MASK:
        begin
          if (s_r.wstrb[0])
            s_nxt.irq_mask = wr_irq;
        end
        default:
          s_nxt.bresp = ufc_pkg::UFC_RESP_SLVERR;
      endcase
    end

    // Set wins over a clear in the same cycle
    s_nxt.irq_status = s_nxt.irq_status | events;

    // Write response retires on its handshake
    if (s_r.bvalid && s_axil_bready)
      s_nxt.bvalid = 1'b0;

    // Read data retires on its handshake
    if (s_r.rvalid && s_axil_rready)
      s_nxt.rvalid = 1'b0;

    // Read: data registered one cycle after the address is taken
    if (rd_fire)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = ufc_pkg::UFC_RESP_OKAY;
      s_nxt.rdata = '0;
      unique case (rd_ofs)
        ufc_pkg::UFC_OFS_FIFO_CONTROL:
        begin
          s_nxt.rdata = '0;
        end
        ufc_pkg::UFC_OFS_ENHANCED:
          s_nxt.rdata[ufc_pkg::UFC_EFR_ENH_BIT] = s_r.efr_enh;
        ufc_pkg::UFC_OFS_HOLDING:
        begin
          // Empty store reads zero rather than stale data
          if (!rx_empty)
            s_nxt.rdata[ENTRY_W-1:0] = {rx_word.err, rx_word.data};
        end
        ufc_pkg::UFC_OFS_STATUS:
          s_nxt.rdata = status;
        ufc_pkg::UFC_OFS_IRQ_STATUS:
          s_nxt.rdata[3:0] = s_r.irq_status;
        ufc_pkg::UFC_OFS_IRQ_MASK:
          s_nxt.rdata[3:0] = s_r.irq_mask;
        default:
          s_nxt.rresp = ufc_pkg::UFC_RESP_SLVERR;
      endcase
    end
  end

  // State register
  // everything, control bits included, resets to zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One write and one read in flight; stall capture while a response waits
  assign s_axil_awready = !s_r.aw_held && !s_r.bvalid;
  assign s_axil_wready = !s_r.w_held && !s_r.bvalid;
  assign s_axil_bvalid = s_r.bvalid;
  assign s_axil_bresp = s_r.bresp;
  assign s_axil_arready = !s_r.rvalid;
  assign s_axil_rvalid = s_r.rvalid;
  assign s_axil_rdata = s_r.rdata;
  assign s_axil_rresp = s_r.rresp;
  // Transmit store drains even when disabled: it still holds the byte
  assign tx_valid = !tx_empty;
  // enable seen by the rest of the channel
  assign fifo_enable = s_r.fifo_control.fifo_en;
  assign dma_mode = s_r.fifo_control.dma_mode;
  assign rx_trigger = s_r.rx_hit;
  assign tx_trigger = s_r.tx_hit;
  // Level interrupt from any unmasked sticky bit
  assign irq = |(s_r.irq_status & s_r.irq_mask);

endmodule : ufc_top

`default_nettype wire

// File: verification/ufc_sva.sv
// Port-level assertions for the UART FIFO control block
`timescale 1ns/1ps
`default_nettype none
module ufc_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_rvalid,
  input wire logic [31:0] s_axil_rdata,
  // Stream and mode outputs
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic fifo_enable,
  input wire logic dma_mode
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_clear_a: assert property ($rose(aresetn) |-> !fifo_enable && !dma_mode)
    else $error("Mode outputs set after reset");
  write_resp_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
    |-> ##2 s_axil_bvalid)
    else $error("Write answer late");
  write_gate_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("Write taken while answer pending");
  read_resp_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("Read answer late");
  read_gate_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("Read taken while answer pending");
  ctrl_read_a: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr[7:2] == 6'h00 |=> s_axil_rdata == 32'h0)
    else $error("Control word readable");
  tx_head_a: assert property (tx_valid && !tx_ready |=> !tx_valid || $stable(tx_data))
    else $error("Transmit head moved while stalled");
  mode_write_a: assert property ($past(aresetn) && ($changed(dma_mode) || $changed(fifo_enable)) |-> $rose(s_axil_bvalid))
    else $error("Mode changed without a write");
endmodule : ufc_sva
bind ufc_top ufc_sva u_sva (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
  .s_axil_bvalid, .s_axil_arvalid, .s_axil_arready, .s_axil_araddr, .s_axil_rvalid, .s_axil_rdata, .tx_valid,
  .tx_ready, .tx_data, .fifo_enable, .dma_mode);
`default_nettype wire

// File: verification/ufc_partner.sv
// Far-side model: transmit shift register and receive character source
`timescale 1ns/1ps
`default_nettype none
module ufc_partner (
  // Transmit side
  input wire logic aclk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic stall,
  output logic tx_ready,
  // Receive side
  output logic rx_valid = 1'b0,
  output ufc_pkg::ufc_rx_entry_t rx_entry = '0
);
  logic [7:0] got [$]; // Bytes already in the shift register
  // Takes every byte unless the bench stalls it
  assign tx_ready = !stall;
  always @(posedge aclk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  // One-cycle pulse; the line shows the inverse between characters
  task automatic send(input ufc_pkg::ufc_rx_entry_t e);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_entry <= e;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_entry <= ~e;
  endtask : send
endmodule : ufc_partner
`default_nettype wire

// File: verification/tb_uart_fifo_control.sv
// Self-checking bench for the UART FIFO control block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_control;
  // Bench-driven inputs, all defined at time zero
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, stall = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  // Design and far-side model outputs
  logic awr, wr, bv, arr, rv, txv, txr, rxv, fen, dma, rxt, txt, irq;
  logic [1:0] br, rr, resp;
  logic [7:0] txd;
  logic [31:0] rdata;
  ufc_pkg::ufc_rx_entry_t rxe;
  int miscompares = 0, samples_checked = 0;
  // Row: write address and data, read address, mask, expected masked word
  typedef struct {logic [7:0] wa; logic [31:0] d; logic [7:0] ra; logic [31:0] m; logic [31:0] e;} ufc_row_t;
  ufc_row_t rows [8] = '{'{8'h04, 32'h10, 8'h0C, 32'h0400_0000, 32'h0400_0000},
    '{8'h00, 32'h09, 8'h0C, 32'h00FF_0000, 32'h0009_0000}, '{8'h00, 32'h51, 8'h0C, 32'h00FF_0000, 32'h0051_0000},
    '{8'h00, 32'hA1, 8'h0C, 32'h00FF_0000, 32'h00A1_0000}, '{8'h00, 32'hF9, 8'h00, 32'hFFFF_FFFF, 32'h0},
    '{8'h00, 32'hF9, 8'h0C, 32'h00FF_0000, 32'h00F9_0000}, '{8'h04, 32'h00, 8'h0C, 32'h0400_0000, 32'h0},
    '{8'h00, 32'h01, 8'h0C, 32'h00FF_0000, 32'h0031_0000}};
  always #5 aclk = ~aclk;
  ufc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_awaddr(awa),
    .s_axil_awprot(3'h0), .s_axil_wvalid(wv), .s_axil_wready(wr), .s_axil_wdata(wd), .s_axil_wstrb(4'hF),
    .s_axil_bvalid(bv), .s_axil_bready(bre), .s_axil_bresp(br), .s_axil_arvalid(arv), .s_axil_arready(arr),
    .s_axil_araddr(ara), .s_axil_arprot(3'h0), .s_axil_rvalid(rv), .s_axil_rready(rre), .s_axil_rdata(rdata),
    .s_axil_rresp(rr), .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .rx_valid(rxv), .rx_entry(rxe),
    .fifo_enable(fen), .dma_mode(dma), .rx_trigger(rxt), .tx_trigger(txt), .irq(irq));
  ufc_partner far (.aclk(aclk), .tx_valid(txv), .tx_data(txd), .stall(stall), .tx_ready(txr), .rx_valid(rxv),
    .rx_entry(rxe));
  // Verdict and end of run
  task automatic test_done;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // Counted compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A spent wait bound counts as a mismatch and ends the run
  task automatic guard(input int n);
    if (n >= 50)
    begin
      miscompares++;
      test_done();
    end
  endtask : guard
  // Write: each channel released at its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
      n++;
    end
    while (!bv && n < 50);
    resp = br;
    guard(n);
  endtask : axw
  // Read: data taken at the edge that sees rvalid
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
      n++;
    end
    while (!rv && n < 50);
    rd = rdata;
    guard(n);
  endtask : axr
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({28'h0, fen, dma, irq, txv}, 32'h0);
    axr(8'h0C);
    chk(rd & 32'h00FF_FFFF, 32'h0);
    foreach (rows[i])
    begin
      axw(rows[i].wa, rows[i].d);
      axr(rows[i].ra);
      chk(rd & rows[i].m, rows[i].e);
    end
    chk({30'h0, fen, dma}, 32'h2);
    // Receive level 8: seven stay below, the eighth reaches it
    repeat (7) far.send(11'h3A5);
    repeat (2) @(posedge aclk);
    chk({31'h0, rxt}, 32'h0);
    far.send(11'h3A5);
    repeat (2) @(posedge aclk);
    chk({30'h0, rxt, irq}, 32'h2);
    axw(8'h14, 32'h1);
    chk({31'h0, irq}, 32'h1);
    axw(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h0);
    axr(8'h08);
    chk(rd, 32'h3A5);
    axw(8'h00, 32'h33);
    axr(8'h0C);
    chk(rd & 32'h0002_00FF, 32'h0);
    // Nine bytes queued, one let through, then flushed
    for (int i = 1; i < 10; i++)
      axw(8'h08, 32'(i));
    stall <= 1'b0;
    @(posedge aclk);
    stall <= 1'b1;
    chk({31'h0, txt}, 32'h0);
    axw(8'h00, 32'h31);
    chk({30'h0, txv, txt}, 32'h3);
    axw(8'h00, 32'h35);
    @(posedge aclk);
    chk({31'h0, txv}, 32'h0);
    chk({24'h0, far.got[0]}, 32'h1);
    axr(8'h0C);
    chk(rd & 32'h0004_FF00, 32'h0);
    // Disabled receive overwrites slot zero
    axw(8'h00, 32'h30);
    far.send(11'h111);
    far.send(11'h222);
    axr(8'h08);
    chk(rd, 32'h222);
    axw(8'h18, 32'h0);
    axr(8'h18);
    chk({28'h0, resp, rr}, 32'hA);
    test_done();
  end
endmodule : tb_uart_fifo_control
`default_nettype wire
